// ===== hw/ppi_port_irq.sv
// port pin interrupt logic with drive select and axi4-lite registers
`timescale 1ns/1ps
module ppi_port_irq
    import ppi_pkg::*;
#(
    parameter int NPORTS = PPI_NUM_PORTS,
    parameter int NPINS  = PPI_PORT_PINS
)(
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire logic [NPORTS*NPINS-1:0] i_pins,
    input  wire logic [NPINS-1:0]        i_port_c_dir_out,
    output logic [NPINS-1:0]             o_port_c_high_drive,
    output logic [NPORTS-1:0]            o_port_irq,
    output logic                         o_wakeup,
    output logic                         o_irq,
    input  wire logic [PPI_ADDR_W-1:0]   i_awaddr,
    input  wire logic                    i_awvalid,
    output logic                         o_awready,
    input  wire logic [31:0]             i_wdata,
    input  wire logic [3:0]              i_wstrb,
    input  wire logic                    i_wvalid,
    output logic                         o_wready,
    output logic [1:0]                   o_bresp,
    output logic                         o_bvalid,
    input  wire logic                    i_bready,
    input  wire logic [PPI_ADDR_W-1:0]   i_araddr,
    input  wire logic                    i_arvalid,
    output logic                         o_arready,
    output logic [31:0]                  o_rdata,
    output logic [1:0]                   o_rresp,
    output logic                         o_rvalid,
    input  wire logic                    i_rready
);
    // three ports of eight pins give the twenty-four interrupt pins
    localparam int NP = NPORTS * NPINS;

    // pin synchroniser and previous-sample state
    logic [NP-1:0]       sync1_q, sync2_q, prev_q, armed_q;
    logic [NP-1:0]       armed_d;
    // per-port control
    logic [NPINS-1:0]    sel_q   [NPORTS];
    logic [NPINS-1:0]    sel_d   [NPORTS];
    logic [NPINS-1:0]    pol_q   [NPORTS];
    logic [NPINS-1:0]    pol_d   [NPORTS];
    logic [NPORTS-1:0]   mode_q, mode_d, ie_q, ie_d, flag_q, flag_d;
    logic [NPORTS-1:0]   hit_edge, hit_level, ack;
    logic [NPINS-1:0]    drv_q, drv_d;
    logic [NPORTS-1:0]   stat_q, stat_d, mask_q, mask_d;
    // bus state
    logic                aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
    logic [PPI_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0]         wdata_q, wdata_d, rdata_q, rdata_d;
    logic                wstb0_q, wstb0_d, rvalid_q, rvalid_d;
    logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
    logic                wr_fire, rd_fire, wr_hit, rd_hit;
    logic [31:0]         rd_val;
    logic [PPI_ADDR_W-1:0] araddr_al;
    logic [NP-1:0]       hit_edge_pin, hit_level_pin;

    // low address bits ignored on reads as on writes
    assign araddr_al = {i_araddr[PPI_ADDR_W-1:2], 2'b00};

    // two-stage sync: only sync2 feeds logic
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
            armed_q <= '0;
        end
        else
        begin
            sync1_q <= i_pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            armed_q <= armed_d;
        end
    end

    // per-pin edge and level detection
    for (genvar g = 0; g < NP; g++)
    begin : g_pin
        localparam int P = g / NPINS;
        localparam int B = g % NPINS;
        logic asserted, was_asserted, en;
        assign en           = sel_q[P][B];
        assign asserted     = pol_q[P][B] ? sync2_q[g] : ~sync2_q[g];
        assign was_asserted = pol_q[P][B] ? prev_q[g] : ~prev_q[g];
        // armed once deasserted level seen while enabled
        assign armed_d[g]   = en & (armed_q[g] | ~was_asserted);
        // 1->0 (falling) or 0->1 (rising) between cycles
        assign hit_edge_pin[g]  = en & armed_q[g] & ~was_asserted & asserted;
        assign hit_level_pin[g] = en & armed_q[g] & asserted;
    end

    // port flags
    always_comb
    begin
        for (int p = 0; p < NPORTS; p++)
        begin
            hit_edge[p]  = |hit_edge_pin[p*NPINS +: NPINS];
            hit_level[p] = mode_q[p] & (|hit_level_pin[p*NPINS +: NPINS]);
        end
    end

    // status bits set on the same events; mask gates only o_irq
    // register writes, flag set beats acknowledge
    always_comb
    begin
        sel_d  = sel_q;
        pol_d  = pol_q;
        mode_d = mode_q;
        ie_d   = ie_q;
        drv_d  = drv_q;
        mask_d = mask_q;
        ack    = '0;
        stat_d = stat_q | (hit_edge | hit_level);
        if (wr_fire && wstb0_q)
        begin
            for (int p = 0; p < NPORTS; p++)
            begin
                if (awaddr_q == PPI_OFS_SC + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
                begin
                    mode_d[p] = wdata_q[PPI_SC_MOD];
                    ie_d[p]   = wdata_q[PPI_SC_IE];
                    ack[p]    = wdata_q[PPI_SC_ACK];
                end
                if (awaddr_q == PPI_OFS_PS + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
                    sel_d[p] = wdata_q[NPINS-1:0];
                if (awaddr_q == PPI_OFS_ES + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
                    pol_d[p] = wdata_q[NPINS-1:0];
            end
            if (awaddr_q == PPI_OFS_DRV)
                drv_d = wdata_q[NPINS-1:0];
            if (awaddr_q == PPI_OFS_MASK)
                mask_d = wdata_q[NPORTS-1:0];
            if (awaddr_q == PPI_OFS_STAT)
                stat_d = (stat_q & ~wdata_q[NPORTS-1:0]) | hit_edge | hit_level;
        end
        // ack clears, new edge or held level sets again
        flag_d = (flag_q & ~ack) | hit_edge | hit_level;
    end

    // control, flag and status registers
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            for (int p = 0; p < NPORTS; p++)
            begin
                sel_q[p] <= PPI_RST_BYTE[NPINS-1:0];
                pol_q[p] <= PPI_RST_BYTE[NPINS-1:0];
            end
            mode_q <= '0;
            ie_q   <= '0;
            flag_q <= '0;
            drv_q  <= PPI_RST_BYTE[NPINS-1:0];
            stat_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            sel_q  <= sel_d;
            pol_q  <= pol_d;
            mode_q <= mode_d;
            ie_q   <= ie_d;
            flag_q <= flag_d;
            drv_q  <= drv_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // requests to processor and wake-up
    assign o_port_irq = flag_q & ie_q;
    assign o_wakeup   = |(flag_q & ie_q);
    assign o_irq      = |(stat_q & mask_q);
    // high drive only on output pins
    assign o_port_c_high_drive = drv_q & i_port_c_dir_out;

    // read mux
    always_comb
    begin
        rd_val = '0;
        rd_hit = 1'b0;
        for (int p = 0; p < NPORTS; p++)
        begin
            if (araddr_al == PPI_OFS_SC + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
            begin
                rd_hit             = 1'b1;
                rd_val[PPI_SC_MOD] = mode_q[p];
                rd_val[PPI_SC_IE]  = ie_q[p];
                rd_val[PPI_SC_IF]  = flag_q[p];
            end
            if (araddr_al == PPI_OFS_PS + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
            begin
                rd_hit              = 1'b1;
                rd_val[NPINS-1:0]   = sel_q[p];
            end
            if (araddr_al == PPI_OFS_ES + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
            begin
                rd_hit              = 1'b1;
                rd_val[NPINS-1:0]   = pol_q[p];
            end
        end
        if (araddr_al == PPI_OFS_DRV)
        begin
            rd_hit            = 1'b1;
            rd_val[NPINS-1:0] = drv_q;
        end
        if (araddr_al == PPI_OFS_STAT)
        begin
            rd_hit             = 1'b1;
            rd_val[NPORTS-1:0] = stat_q;
        end
        if (araddr_al == PPI_OFS_MASK)
        begin
            rd_hit             = 1'b1;
            rd_val[NPORTS-1:0] = mask_q;
        end
    end

    // write address decode
    always_comb
    begin
        wr_hit = (awaddr_q == PPI_OFS_DRV) || (awaddr_q == PPI_OFS_STAT) || (awaddr_q == PPI_OFS_MASK);
        for (int p = 0; p < NPORTS; p++)
            if (awaddr_q == PPI_OFS_SC + PPI_ADDR_W'(p) * PPI_PORT_STRIDE ||
                awaddr_q == PPI_OFS_PS + PPI_ADDR_W'(p) * PPI_PORT_STRIDE ||
                awaddr_q == PPI_OFS_ES + PPI_ADDR_W'(p) * PPI_PORT_STRIDE)
                wr_hit = 1'b1;
    end

    // axi4-lite channel handshakes
    assign o_awready = ~aw_have_q & ~bvalid_q;
    assign o_wready  = ~w_have_q & ~bvalid_q;
    assign o_arready = ~rvalid_q;
    // bvalid blocks new writes, so one write is outstanding at a time
    assign wr_fire   = aw_have_q & w_have_q & ~bvalid_q;
    assign rd_fire   = i_arvalid & o_arready;

    // next state of the write and read channels
    always_comb
    begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstb0_d   = wstb0_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (i_awvalid && o_awready)
        begin
            aw_have_d = 1'b1;
            awaddr_d  = {i_awaddr[PPI_ADDR_W-1:2], 2'b00};
        end
        if (i_wvalid && o_wready)
        begin
            w_have_d = 1'b1;
            wdata_d  = i_wdata;
            wstb0_d  = i_wstrb[0];
        end
        if (wr_fire)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? PPI_RESP_OKAY : PPI_RESP_SLVERR;
        end
        else if (bvalid_q && i_bready)
            bvalid_d = 1'b0;
        if (rd_fire)
        begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_hit ? PPI_RESP_OKAY : PPI_RESP_SLVERR;
        end
        else if (rvalid_q && i_rready)
            rvalid_d = 1'b0;
    end

    // bus channel registers
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstb0_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= PPI_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= PPI_RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstb0_q   <= wstb0_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // registered responses
    assign o_bvalid = bvalid_q;
    assign o_bresp  = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata  = rdata_q;
    assign o_rresp  = rresp_q;
endmodule

// ===== hw/ppi_pkg.sv
// package of constants for the port pin interrupt block
package ppi_pkg;
    localparam int          PPI_NUM_PORTS   = 3;
    localparam int          PPI_PORT_PINS   = 8;
    localparam int          PPI_ADDR_W      = 8;
    // per-port register block: base + port * stride
    localparam logic [7:0]  PPI_PORT_STRIDE = 8'h10;
    localparam logic [7:0]  PPI_OFS_SC      = 8'h00;
    localparam logic [7:0]  PPI_OFS_PS      = 8'h04;
    localparam logic [7:0]  PPI_OFS_ES      = 8'h08;
    localparam logic [7:0]  PPI_OFS_DRV     = 8'h30;
    localparam logic [7:0]  PPI_OFS_STAT    = 8'h34;
    localparam logic [7:0]  PPI_OFS_MASK    = 8'h38;
    // status and control field positions
    localparam int          PPI_SC_MOD      = 0;
    localparam int          PPI_SC_IE       = 1;
    localparam int          PPI_SC_ACK      = 2;
    localparam int          PPI_SC_IF       = 3;
    // reset value and bus response codes
    localparam logic [7:0]  PPI_RST_BYTE    = 8'h00;
    localparam logic [1:0]  PPI_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  PPI_RESP_SLVERR = 2'b10;
endpackage

// ===== verification/ppi_port_irq_assertions.sv
// assertions on the port pin interrupt block ports
`timescale 1ns/1ps
module ppi_port_irq_assertions
    import ppi_pkg::*;
#(
    parameter int NPORTS = PPI_NUM_PORTS,
    parameter int NPINS  = PPI_PORT_PINS
)(
    input wire logic              i_clk,
    input wire logic              i_reset,
    input wire logic [NPINS-1:0]  i_port_c_dir_out,
    input wire logic [NPINS-1:0]  o_port_c_high_drive,
    input wire logic [NPORTS-1:0] o_port_irq,
    input wire logic              o_wakeup,
    input wire logic              i_awvalid,
    input wire logic              o_awready,
    input wire logic              i_wvalid,
    input wire logic              o_wready,
    input wire logic              o_bvalid,
    input wire logic              i_bready,
    input wire logic              i_arvalid,
    input wire logic              o_arready,
    input wire logic              o_rvalid,
    input wire logic              i_rready
);
    // all checks on the bus clock, quiet in reset
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    property p_wake; o_wakeup == (|o_port_irq); endproperty
    a_wake: assert property (p_wake) else $error("wakeup not or of requests");
    property p_drv; (o_port_c_high_drive & ~i_port_c_dir_out) == '0; endproperty
    a_drv: assert property (p_drv) else $error("high drive on input pin");
    property p_wans; i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid; endproperty
    a_wans: assert property (p_wans) else $error("write answer late");
    property p_bdrop; o_bvalid && i_bready |=> !o_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer stuck");
    property p_awblk; o_bvalid |-> !o_awready && !o_wready; endproperty
    a_awblk: assert property (p_awblk) else $error("write taken while answering");
    property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_rdrop; o_rvalid && i_rready |=> !o_rvalid; endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer stuck");
    property p_arblk; o_rvalid |-> !o_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken while answering");
endmodule

bind ppi_port_irq ppi_port_irq_assertions #(.NPORTS(NPORTS), .NPINS(NPINS)) i_chk (.i_clk, .i_reset,
    .i_port_c_dir_out, .o_port_c_high_drive, .o_port_irq, .o_wakeup, .i_awvalid, .o_awready, .i_wvalid,
    .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready);

// ===== verification/ppi_pin_source.sv
// model of the outside world driving the interrupt-capable pins
`timescale 1ns/1ps
module ppi_pin_source #(
    parameter int W = 24
)(
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_level,
    output logic      [W-1:0] o_pins
);
    // pins move off the bus edge, unrelated to sampling
    initial o_pins = '0;
    always @(negedge i_clk)
        o_pins <= i_level;
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the port pin interrupt block
`timescale 1ns/1ps
module tb_top;
    import ppi_pkg::*;
    logic        i_clk, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_wakeup, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [7:0]  i_port_c_dir_out, i_awaddr, i_araddr, o_port_c_high_drive;
    logic [31:0] i_wdata, o_rdata, v;
    logic [23:0] lvl, i_pins;
    logic [3:0]  i_wstrb;
    logic [2:0]  o_port_irq;
    logic [1:0]  o_bresp, o_rresp, s;
    int          num_errors, n_tests, p, q;
    // register rows: address, write value, readback, response
    logic [7:0]  t_a [6] = '{8'h00, 8'h18, 8'h24, 8'h30, 8'h38, 8'h3c};
    logic [7:0]  t_w [6] = '{8'h07, 8'h5a, 8'hff, 8'ha5, 8'h07, 8'hff};
    logic [7:0]  t_r [6] = '{8'h03, 8'h5a, 8'hff, 8'ha5, 8'h07, 8'h00};
    logic [1:0]  t_s [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, PPI_RESP_SLVERR};

    ppi_pin_source i_src (.i_clk, .i_level(lvl), .o_pins(i_pins));
    ppi_port_irq i_dut (.i_clk, .i_reset, .i_pins, .i_port_c_dir_out, .o_port_c_high_drive, .o_port_irq,
        .o_wakeup, .o_irq, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
        .i_rready);

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // compare and count
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
            num_errors++;
        end
    endtask

    // one bus access, each channel dropped when taken
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rv, output logic [1:0] rs);
        logic ta, tw, tr, dn;
        @(posedge i_clk);
        i_awaddr <= a;
        i_araddr <= a;
        i_wdata <= d;
        i_awvalid <= w;
        i_wvalid <= w;
        i_bready <= w;
        i_arvalid <= !w;
        i_rready <= !w;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge i_clk);
            ta = i_awvalid & o_awready;
            tw = i_wvalid & o_wready;
            tr = i_arvalid & o_arready;
            dn = w ? o_bvalid : o_rvalid;
            rs = w ? o_bresp : o_rresp;
            rv = o_rdata;
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            if (tr) i_arvalid <= 1'b0;
            if (dn)
            begin
                i_bready <= 1'b0;
                i_rready <= 1'b0;
                return;
            end
        end
        num_errors++;
        report_and_stop;
    endtask

    // bounded wait for a port request
    task automatic poll(input int n);
        for (int k = 0; k < 10; k++)
        begin
            @(negedge i_clk);
            if (o_port_irq[n] === 1'b1)
                break;
        end
        chk("port irq", o_port_irq[n], 1);
        if (o_port_irq[n] !== 1'b1)
            report_and_stop;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    initial
    begin
        {i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
        {i_awaddr, i_araddr, i_wdata, lvl, num_errors, n_tests} = '0;
        i_wstrb = 4'hf;
        i_port_c_dir_out = 8'h0f;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        for (q = 0; q < 6; q++)
        begin
            bus(0, t_a[q], 0, v, s);
            chk("reset value", v, 0);
            bus(1, t_a[q], 32'(t_w[q]), v, s);
            chk("bresp", s, t_s[q]);
            bus(0, t_a[q], 0, v, s);
            chk("readback", v, 32'(t_r[q]));
            chk("rresp", s, t_s[q]);
        end
        chk("drive gated", o_port_c_high_drive, 8'h05);
        @(posedge i_clk);
        i_port_c_dir_out <= 8'hff;
        @(negedge i_clk);
        chk("drive", o_port_c_high_drive, 8'ha5);
        $display("registers done");
        // each port, both polarities, flag then acknowledge
        for (p = 0; p < 3; p++)
            for (q = 0; q < 2; q++)
            begin
                lvl[p*8+3] = !q[0];
                bus(1, 8'(p*16+8), 32'(q << 3), v, s);
                bus(1, 8'(p*16+4), 8'h08, v, s);
                bus(1, 8'(p*16), 8'h02, v, s);
                repeat (5) @(posedge i_clk);
                lvl[p*8+3] = q[0];
                poll(p);
                chk("irq", o_irq, 1);
                bus(0, 8'(p*16), 0, v, s);
                chk("flag", v[3], 1);
                bus(1, 8'(p*16), 8'h06, v, s);
                bus(0, 8'(p*16), 0, v, s);
                chk("ack", v[3], 0);
                bus(1, 8'h34, 32'(1 << p), v, s);
                chk("status clear", o_irq, 0);
                bus(1, 8'(p*16+4), 0, v, s);
            end
        $display("edges done");
        // pin active when enabled, and a pin left disabled
        lvl[9] = 1'b1;
        bus(1, 8'h18, 8'h02, v, s);
        bus(1, 8'h14, 8'h02, v, s);
        bus(1, 8'h10, 8'h02, v, s);
        lvl[10] = 1'b1;
        repeat (6) @(posedge i_clk);
        lvl[10] = 1'b0;
        repeat (6) @(negedge i_clk);
        chk("not armed", o_port_irq[1], 0);
        lvl[9] = 1'b0;
        repeat (5) @(posedge i_clk);
        lvl[9] = 1'b1;
        poll(1);
        $display("arming done");
        // level mode with a low level, port c masked
        bus(1, 8'h34, 8'h07, v, s);
        bus(1, 8'h38, 8'h03, v, s);
        lvl[16] = 1'b1;
        bus(1, 8'h28, 0, v, s);
        bus(1, 8'h24, 8'h01, v, s);
        bus(1, 8'h20, 8'h03, v, s);
        repeat (5) @(posedge i_clk);
        lvl[16] = 1'b0;
        poll(2);
        bus(1, 8'h20, 8'h07, v, s);
        repeat (4) @(negedge i_clk);
        chk("level held", o_port_irq[2], 1);
        chk("wakeup", o_wakeup, 1);
        chk("masked", o_irq, 0);
        lvl[16] = 1'b1;
        repeat (5) @(posedge i_clk);
        bus(1, 8'h20, 8'h07, v, s);
        @(negedge i_clk);
        chk("released", o_port_irq[2], 0);
        $display("level done");
        // reset in mid-run clears the pending port b request and bus state
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("reset irq", {o_port_irq, o_wakeup, o_irq}, 0);
        chk("reset ready", {o_awready, o_wready, o_arready, o_bvalid, o_rvalid}, 5'h1c);
        @(posedge i_clk);
        i_reset <= 1'b0;
        bus(0, 8'h10, 0, v, s);
        chk("reset sc", v, 0);
        $display("reset done");
        report_and_stop;
    end
endmodule
